// ===== shared/nand_status_pkg.sv
package nand_status_pkg;

    // Register offsets of the controller's own APB map.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD  = 8'h04;
    localparam logic [7:0] REG_ROW  = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;

    // Control register bit positions and reset value.
    localparam int         CTRL_WP_RELEASE = 0;
    localparam int         CTRL_POLL       = 1;
    localparam int         CTRL_WAIT_ARRAY = 2;
    localparam int         CTRL_OTP        = 3;
    localparam logic [3:0] CTRL_RESET      = 4'h0;

    // Operation codes written to the command register.
    localparam logic [1:0] OP_STATUS     = 2'h0;
    localparam logic [1:0] OP_STATUS_ENH = 2'h1;
    localparam logic [1:0] OP_READ       = 2'h2;

    // Command bytes sent on the flash data lines.
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
    localparam logic [7:0] CMD_READ       = 8'h00;

    // Bit positions within the flash status byte.
    localparam int         SB_FAIL        = 0;
    localparam int         SB_PREV_FAIL   = 1;
    localparam int         SB_ARRAY_READY = 5;
    localparam int         SB_READY       = 6;
    localparam int         SB_NOT_PROT    = 7;
    localparam logic [7:0] SB_DEFINED     = 8'he3;

    // Bit positions above the status byte in the status register.
    localparam int STAT_BUSY       = 8;
    localparam int STAT_RB_READY   = 9;
    localparam int STAT_REFUSED    = 10;
    localparam int STAT_VALID      = 11;
    localparam int STAT_FAIL_VALID = 12;

    // Pin timing in ns and derived cycle counts at the pclk rate.
    localparam int CLK_NS    = 25;
    localparam int T_WHR_NS  = 60;
    localparam int T_REA_NS  = 20;
    localparam int T_RHW_NS  = 100;
    localparam int SYNC_LAT  = 2;
    localparam int WHR_CYC   = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
    localparam int REA_CYC   = (T_REA_NS + CLK_NS - 1) / CLK_NS;
    localparam int RHW_CYC   = (T_RHW_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_BYTES = 3;

    // Controller sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WR_LOW = 3'b001,
        ST_WR_HI  = 3'b010,
        ST_WHR    = 3'b011,
        ST_RD     = 3'b100,
        ST_RHW    = 3'b101
    } state_t;

    // Flash pins driven by the controller.
    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       read_strobe_n;
        logic       wp_n;
        logic [7:0] io_out;
        logic       io_oe;
    } nand_pins_t;

endpackage

// ===== src/nand_status_host.sv
`timescale 1ns/10ps
module nand_status_host (
    // Clock and reset.
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave.
    input  wire logic [7:0]                 paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Flash pins.
    input  wire logic [7:0]                 io_in,
    input  wire logic                       ready_busy_n,
    output nand_status_pkg::nand_pins_t     pins
);
    import nand_status_pkg::*;

    logic [7:0]  io_s1;
    logic [7:0]  io_s2;
    logic        rb_s1;
    logic        rb_s2;
    logic [3:0]  ctrl;
    logic [23:0] row;
    logic [1:0]  op;
    logic [7:0]  stat_byte;
    logic        stat_valid;
    logic        refused;
    state_t      state;
    logic [2:0]  cnt;
    logic [1:0]  byte_idx;
    state_t      next_state;
    logic [2:0]  next_cnt;
    logic [1:0]  next_idx;
    nand_pins_t  next_pins;
    logic [7:0]  next_stat;
    logic        next_valid;

    // Picks one row address byte, lowest byte first.
    function automatic logic [7:0] row_byte(input logic [23:0] r,
                                            input logic [1:0]  i);
        logic [7:0] b;
        b = r[7:0];
        if (i == 2'd1) begin
            b = r[15:8];
        end else if (i == 2'd2) begin
            b = r[23:16];
        end
        return b;
    endfunction

    // Tells whether a sampled status byte ends the poll.
    function automatic logic poll_done(input logic [7:0] s,
                                       input logic       wait_array);
        return wait_array ? s[SB_ARRAY_READY] : s[SB_READY];
    endfunction

    // APB decode and command acceptance.
    wire setup     = psel & ~penable;
    wire wr_access = psel & penable & pready & pwrite;
    wire hit_ctrl  = (paddr == REG_CTRL);
    wire hit_cmd   = (paddr == REG_CMD);
    wire hit_row   = (paddr == REG_ROW);
    wire hit_stat  = (paddr == REG_STAT);
    wire hit_any   = hit_ctrl | hit_cmd | hit_row | hit_stat;
    wire [1:0] wr_op = pwdata[1:0];
    wire otp_block = (wr_op == OP_STATUS_ENH) & ctrl[CTRL_OTP];
    // Only status and read ops exist: no program or multi-plane order.
    wire legal_op  = (wr_op != 2'h3) & ~otp_block;
    wire cmd_go    = wr_access & hit_cmd & (state == ST_IDLE) & legal_op;
    wire cmd_bad   = wr_access & hit_cmd & ~cmd_go;
    wire [1:0] byte_last = (op == OP_STATUS_ENH) ? 2'(ROW_BYTES) : 2'd0;
    wire [7:0] go_byte = (wr_op == OP_STATUS)     ? CMD_STATUS :
                         (wr_op == OP_STATUS_ENH) ? CMD_STATUS_ENH :
                         CMD_READ;
    wire [7:0] masked_io = io_s2 & SB_DEFINED;
    wire [31:0] stat_word = {19'h0,
                             stat_valid & stat_byte[SB_ARRAY_READY],
                             stat_valid, refused, rb_s2,
                             state != ST_IDLE, stat_byte};
    wire [31:0] rd_word = hit_ctrl ? {28'h0, ctrl} :
                          hit_cmd  ? {30'h0, op} :
                          hit_row  ? {8'h0, row} :
                          hit_stat ? stat_word : 32'h0;

    // Two-flop synchronisers for the data lines and ready/busy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_s1 <= 8'h00;
            io_s2 <= 8'h00;
            rb_s1 <= 1'b0;
            rb_s2 <= 1'b0;
        end else begin
            io_s1 <= io_in;
            io_s2 <= io_s1;
            rb_s1 <= ready_busy_n;
            rb_s2 <= rb_s1;
        end
    end

    // APB answer registered in the setup cycle, so no wait states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            prdata  <= setup ? rd_word : 32'h0;
            pslverr <= setup & ~hit_any;
        end
    end

    // Software registers; a refused command sets the sticky flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= CTRL_RESET;
            row     <= 24'h0;
            op      <= OP_STATUS;
            refused <= 1'b0;
        end else begin
            if (wr_access & hit_ctrl) begin
                ctrl <= pwdata[3:0];
            end
            if (wr_access & hit_row) begin
                row <= pwdata[23:0];
            end
            if (cmd_go) begin
                op <= wr_op;
            end
            if (cmd_bad) begin
                refused <= 1'b1;
            end else if (wr_access & hit_stat & pwdata[STAT_REFUSED]) begin
                refused <= 1'b0;
            end
        end
    end

    // Pin sequencer: command byte, row bytes, then status reads.
    always_comb begin
        next_state     = state;
        next_cnt       = (cnt != 3'd0) ? cnt - 3'd1 : 3'd0;
        next_idx       = byte_idx;
        next_pins      = pins;
        next_pins.wp_n = ctrl[CTRL_WP_RELEASE];
        next_stat      = stat_byte;
        next_valid     = stat_valid;
        case (state)
            ST_IDLE: begin
                if (cmd_go) begin
                    next_pins.ce_n   = 1'b0;
                    next_pins.cle    = 1'b1;
                    next_pins.ale    = 1'b0;
                    next_pins.we_n   = 1'b0;
                    next_pins.io_out = go_byte;
                    next_pins.io_oe  = 1'b1;
                    next_idx         = 2'd0;
                    next_valid       = 1'b0;
                    next_state       = ST_WR_LOW;
                end
            end
            ST_WR_LOW: begin
                next_pins.we_n = 1'b1;
                next_state     = ST_WR_HI;
            end
            ST_WR_HI: begin
                if (byte_idx == byte_last) begin
                    next_pins.cle   = 1'b0;
                    next_pins.ale   = 1'b0;
                    next_pins.io_oe = 1'b0;
                    if (op == OP_READ) begin
                        next_pins.ce_n = 1'b1;
                        next_state     = ST_IDLE;
                    end else begin
                        next_cnt   = 3'(WHR_CYC - 1);
                        next_state = ST_WHR;
                    end
                end else begin
                    next_pins.cle    = 1'b0;
                    next_pins.ale    = 1'b1;
                    next_pins.we_n   = 1'b0;
                    next_pins.io_out = row_byte(row, byte_idx);
                    next_idx         = byte_idx + 2'd1;
                    next_state       = ST_WR_LOW;
                end
            end
            ST_WHR: begin
                if (cnt == 3'd0) begin
                    next_pins.read_strobe_n = 1'b0;
                    next_cnt   = 3'(REA_CYC + SYNC_LAT - 1);
                    next_state = ST_RD;
                end
            end
            ST_RD: begin
                if (cnt == 3'd0) begin
                    next_stat  = masked_io;
                    next_valid = 1'b1;
                    if (!ctrl[CTRL_POLL] ||
                        poll_done(masked_io, ctrl[CTRL_WAIT_ARRAY])) begin
                        next_pins.read_strobe_n = 1'b1;
                        next_pins.ce_n          = 1'b1;
                        next_cnt   = 3'(RHW_CYC - 1);
                        next_state = ST_RHW;
                    end
                end
            end
            ST_RHW: begin
                if (cnt == 3'd0) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers; pins idle with everything deasserted except wp_n, which resets low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_IDLE;
            cnt        <= 3'd0;
            byte_idx   <= 2'd0;
            pins       <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                            read_strobe_n: 1'b1, wp_n: 1'b0,
                            io_out: 8'h00, io_oe: 1'b0};
            stat_byte  <= 8'h00;
            stat_valid <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            byte_idx   <= next_idx;
            pins       <= next_pins;
            stat_byte  <= next_stat;
            stat_valid <= next_valid;
        end
    end

    // Checks on the sequencer and the APB answer.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_apb_ready_setup: assert property (setup |=> pready)
        else $error("pready missing after setup");
    a_status_cmd_byte: assert property (
        cmd_go && wr_op == OP_STATUS
        |=> pins.cle && pins.io_out == CMD_STATUS && !pins.we_n)
        else $error("status command byte not driven");
    a_resume_read: assert property (
        cmd_go && wr_op == OP_READ
        |=> pins.io_out == CMD_READ ##2 pins.ce_n && state == ST_IDLE)
        else $error("read command not issued");
    a_enh_row_cycles: assert property (
        cmd_go && wr_op == OP_STATUS_ENH
        |=> pins.cle ##2 pins.ale ##2 pins.ale ##2 pins.ale ##2 !pins.ale)
        else $error("enhanced status lacks three row cycles");
    a_otp_refused: assert property (
        wr_access && hit_cmd && wr_op == OP_STATUS_ENH && ctrl[CTRL_OTP]
        |=> refused && !(pins.cle && !pins.we_n))
        else $error("enhanced status issued in otp mode");
    a_strobe_under_ce: assert property (
        !pins.read_strobe_n |-> !pins.ce_n && !pins.io_oe)
        else $error("read strobe low without chip select");
    a_poll_holds_re: assert property (
        state == ST_RD && cnt == 3'd0 && ctrl[CTRL_POLL]
        && !poll_done(masked_io, ctrl[CTRL_WAIT_ARRAY])
        |=> !pins.read_strobe_n && state == ST_RD)
        else $error("poll released strobe early");
    a_wp_follows_ctrl: assert property (
        ##1 pins.wp_n == $past(ctrl[CTRL_WP_RELEASE]))
        else $error("write protect pin not following control");
    a_undefined_masked: assert property (
        stat_valid |-> stat_byte[4:2] == 3'b000)
        else $error("undefined status bits reported");
    a_whr_gap: assert property (
        state == ST_WR_HI && next_state == ST_WHR
        |=> pins.read_strobe_n [*3] ##1 !pins.read_strobe_n)
        else $error("write to read gap wrong");

    c_status_read: cover property (cmd_go && wr_op == OP_STATUS
                                   ##[1:40] $rose(stat_valid));
    c_enh_read: cover property (cmd_go && wr_op == OP_STATUS_ENH
                                ##[1:60] $rose(stat_valid));
    c_poll_long: cover property (state == ST_RD && cnt == 3'd0
                                 && ctrl[CTRL_POLL] [*4]);
    c_refused: cover property ($rose(refused));

endmodule

// ===== tb/nand_flash_model.sv
`timescale 1ns/10ps
module nand_flash_model #(
    parameter int PLANE_BIT = 6
) (
    // Controller pins and the data wire as the flash sees them.
    input  nand_status_pkg::nand_pins_t pins,
    input  logic [7:0]                  io,
    // Internal device state set by the bench.
    input  logic                        busy,
    input  logic                        array_busy,
    input  logic                        fail0,
    input  logic                        fail1,
    input  logic                        prev_fail,
    input  logic                        protect,
    input  logic                        low_supply,
    // Device outputs.
    output logic [7:0]                  io_val,
    output logic                        rb_oe,
    output logic                        status_mode
);
    import nand_status_pkg::*;

    logic [7:0]  cmd  = 8'hff;
    logic [23:0] row  = 24'h000000;
    logic [7:0]  held = 8'h00;
    logic [7:0]  sb;
    logic        drive;
    logic        plane;
    int          nrow = 0;

    // Command and row bytes are latched on the rising write strobe.
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && !low_supply) begin
            if (pins.cle) begin
                cmd = io;
                nrow = 0;
            end else if (pins.ale && nrow < 3) begin
                row[8*nrow +: 8] = io;
                nrow++;
            end
        end
    end

    // Status mode lasts until the next command byte arrives.
    assign status_mode = (cmd == CMD_STATUS) || (cmd == CMD_STATUS_ENH);
    assign plane = (cmd == CMD_STATUS_ENH) && row[PLANE_BIT];
    // Undefined bits carry a nonzero pattern so that masking is visible.
    assign sb = {pins.wp_n & ~protect, ~busy, ~busy & ~array_busy, 3'b101,
                 prev_fail, plane ? fail1 : fail0};
    // The byte is live while both strobes are low, and tracks state.
    assign drive = status_mode && !pins.ce_n && !pins.read_strobe_n;
    always @(negedge drive) begin
        held = sb;
    end
    // A released bus shows the inverse of the last value, never a hold.
    assign io_val = drive ? sb : ~held;
    // Open-drain pull-down while the device works.
    assign rb_oe = busy;
endmodule

// ===== tb/nand_status_host_tb.sv
`timescale 1ns/10ps
module nand_status_host_tb;
    import nand_status_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, io_in, io_val;
    logic [31:0] pwdata, prdata;
    logic        ready_busy_n, rb_oe, status_mode;
    logic        busy, array_busy, fail0, fail1, prev_fail, protect;
    logic        low_supply;
    nand_pins_t  pins;
    int          mismatches = 0;
    int          tests_run  = 0;

    // Data wire and pulled-up ready/busy wire resolved from all drivers.
    assign io_in = pins.io_oe ? pins.io_out : io_val;
    assign ready_busy_n = rb_oe ? 1'b0 : 1'b1;

    nand_status_host i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_in(io_in),
        .ready_busy_n(ready_busy_n), .pins(pins));
    nand_flash_model i_flash (.pins(pins), .io(io_in), .busy(busy),
        .array_busy(array_busy), .fail0(fail0), .fail1(fail1),
        .prev_fail(prev_fail), .protect(protect), .low_supply(low_supply),
        .io_val(io_val), .rb_oe(rb_oe), .status_mode(status_mode));

    task complete_run;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
    endtask

    task wait_idle;
        logic [31:0] s;
        int          n;
        n = 0;
        do begin
            rd(REG_STAT, s);
            n++;
        end while (s[STAT_BUSY] !== 1'b0 && n < 200);
        chk("busy clears", 32'h0, {31'h0, s[STAT_BUSY]});
    endtask

    // Expected status register after a finished read of one status byte.
    function automatic logic [31:0] exp_stat(input logic b, ab, f, pf, wp);
        logic [7:0] sb;
        sb = {wp, ~b, ~b & ~ab, 3'b000, pf, f};
        return {19'h0, sb[5], 1'b1, 1'b0, ~b, 1'b0, sb};
    endfunction

    task set_dev(input logic b, ab, f0, f1, pf, pr);
        @(posedge pclk);
        busy <= b; array_busy <= ab; fail0 <= f0; fail1 <= f1;
        prev_fail <= pf; protect <= pr;
    endtask

    task t_reset;
        logic [31:0] r;
        rd(REG_CTRL, r);
        chk("ctrl reset", {28'h0, CTRL_RESET}, r);
        chk("wp after reset", 32'h0, {31'h0, pins.wp_n});
        chk("ce after reset", 32'h1, {31'h0, pins.ce_n});
    endtask

    // Plain status reads over a table of device states.
    task t_status;
        logic [5:0]  tbl [6] = '{6'b000001, 6'b001101, 6'b100001,
                                 6'b010111, 6'b000011, 6'b000000};
        logic [31:0] r;
        foreach (tbl[i]) begin
            set_dev(tbl[i][5], tbl[i][4], tbl[i][3], 1'b0, tbl[i][2], tbl[i][1]);
            wr(REG_CTRL, {31'h0, tbl[i][0]});
            wr(REG_CMD, {30'h0, OP_STATUS});
            wait_idle();
            rd(REG_STAT, r);
            chk("status", exp_stat(tbl[i][5], tbl[i][4], tbl[i][3],
                tbl[i][2], tbl[i][0] & ~tbl[i][1]), r);
            chk("status mode", 32'h1, {31'h0, status_mode});
        end
    endtask

    // Enhanced status picks the plane from the row, low byte first.
    task t_enh;
        logic [23:0] rows [2] = '{24'h000040, 24'h404000};
        logic [31:0] r;
        set_dev(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        wr(REG_CTRL, 32'h1);
        foreach (rows[i]) begin
            wr(REG_ROW, {8'h0, rows[i]});
            wr(REG_CMD, {30'h0, OP_STATUS_ENH});
            wait_idle();
            rd(REG_STAT, r);
            chk("enhanced", exp_stat(1'b0, 1'b0, ~i[0], 1'b0, 1'b1), r);
        end
    endtask

    // Polling holds the strobes low and waits on bit 6 or on bit 5.
    task t_poll(input logic wa);
        logic [31:0] r;
        set_dev(~wa, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(REG_CTRL, {29'h0, wa, 2'b11});
        wr(REG_CMD, {30'h0, OP_STATUS});
        repeat (40) @(posedge pclk);
        chk("strobe held", 32'h0, {31'h0, pins.read_strobe_n});
        rd(REG_STAT, r);
        chk("still busy", 32'h1, {31'h0, r[STAT_BUSY]});
        set_dev(1'b0, ~wa, 1'b0, 1'b0, 1'b0, 1'b0);
        wait_idle();
        rd(REG_STAT, r);
        chk("poll result", exp_stat(1'b0, ~wa, 1'b0, 1'b0, 1'b1), r);
        set_dev(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    // A command sent at low supply is ignored, so status mode stays.
    task t_low_supply;
        low_supply <= 1'b1;
        wr(REG_CMD, {30'h0, OP_READ});
        wait_idle();
        chk("low supply lockout", 32'h1, {31'h0, status_mode});
        low_supply <= 1'b0;
    endtask

    task t_read_cmd;
        logic [31:0] r;
        wr(REG_CMD, {30'h0, OP_READ});
        wait_idle();
        chk("status mode left", 32'h0, {31'h0, status_mode});
        rd(REG_CMD, r);
        chk("last op", {30'h0, OP_READ}, r);
    endtask

    // Enhanced status in one-time area mode and op code 3 are refused.
    task t_refuse;
        logic [1:0]  ops [2] = '{OP_STATUS_ENH, 2'h3};
        logic [31:0] r;
        wr(REG_CTRL, 32'h9);
        foreach (ops[i]) begin
            wr(REG_CMD, {30'h0, ops[i]});
            repeat (20) @(posedge pclk);
            chk("no flash command", 32'h0, {31'h0, status_mode});
            rd(REG_STAT, r);
            chk("refused set", 32'h1, {31'h0, r[STAT_REFUSED]});
            wr(REG_STAT, 32'h400);
            rd(REG_STAT, r);
            chk("refused clear", 32'h0, {31'h0, r[STAT_REFUSED]});
        end
        wr(REG_CTRL, 32'h1);
    endtask

    task t_unmapped;
        logic [31:0] r;
        logic        e;
        apb(8'h10, 1'b0, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        complete_run();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; busy = 1'b0; array_busy = 1'b0;
        fail0 = 1'b0; fail1 = 1'b0; prev_fail = 1'b0; protect = 1'b0;
        low_supply = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_status();
        t_enh();
        t_poll(1'b0);
        t_poll(1'b1);
        t_low_supply();
        t_read_cmd();
        t_refuse();
        t_unmapped();
        complete_run();
    end
endmodule
